// File: eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// ==========================================================================
// timing
// ==========================================================================
// self-timed program pulse in microseconds
`define EE_PROG_TIME_US 10000
// reference clock rate in kHz (25 MHz)
`define EE_REF_CLK_KHZ  25000
// program pulse in reference clock cycles (longest time, rounds down)
`define EE_PROG_CYCLES  ((`EE_PROG_TIME_US * `EE_REF_CLK_KHZ) / 1000)
// width of the program timer
`define EE_TIMER_W      18

// ==========================================================================
// instruction format
// ==========================================================================
`define EE_OPC_BITS     5'h02
`define EE_SUB_BITS     5'h04
`define EE_ADDR_BASE    5'h07
`define EE_DATA_X16     5'h10
`define EE_DATA_X8      5'h08
`define EE_OPC_READ     2'h2
`define EE_OPC_ERASE    2'h3
`define EE_OPC_WRITE    2'h1
`define EE_OPC_SPECIAL  2'h0
`define EE_SUB_ENABLE   2'h3
`define EE_SUB_DISABLE  2'h0
`define EE_SUB_CLRALL   2'h2
`define EE_SUB_FILLALL  2'h1

// ==========================================================================
// array
// ==========================================================================
`define EE_BYTES        256
`define EE_LAST_BYTE    8'hFF
`define EE_ERASED_WORD  16'hFFFF

`endif

// File: eeprom_pkg.sv
package eeprom_pkg;

  // instruction receiver states
  typedef enum logic [4:0] {
    RX_OFF  = 5'h01,
    RX_HUNT = 5'h02,
    RX_CMD  = 5'h04,
    RX_READ = 5'h08,
    RX_DONE = 5'h10
  } rx_state_t;

  // self-timed program states
  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_FILL = 3'h2,
    PG_TIME = 3'h4
  } pg_state_t;

  // pending program operation
  typedef enum logic [1:0] {
    OPK_WRITE   = 2'h0,
    OPK_ERASE   = 2'h1,
    OPK_CLRALL  = 2'h2,
    OPK_FILLALL = 2'h3
  } op_kind_t;

endpackage

// File: host_model.sv
// ==========================================================================
// host side of the three-wire link
// ==========================================================================
module host_model (
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic dline;
  // host pull-up holds the line when released
  assign dline = serial_out_en ? serial_out : 1'b1;
  // idle link, clock parked low
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // select with clock low
  task sel();
    chip_select = 1'b1;
    #200;
  endtask
  // deselect for the minimum low time, data no longer meaningful
  task desel();
    chip_select = 1'b0;
    serial_in = ~serial_in;
    #400;
  endtask
  // msb first, data set up before each rise, line read late in high phase
  task shift(input logic [31:0] v, input int n, output logic [31:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = v[i];
      #120 serial_clock = 1'b1;
      #200 r = {r[30:0], dline};
      serial_clock = 1'b0;
    end
  endtask
endmodule

// File: serial_eeprom.sv
// Functional notes
// - x16 instruction is 10 or 11 bits
// - x8 instruction is 11 or 12 bits
// - input bits sampled on serial clock rise
// - output tri-stated except read or status
// - status output low busy, high ready
// - dummy one releases output on clock fall
// - start bit, opcode, address, optional data
// - read emits leading zero then word MSB-first
// - read data changes on serial clock rise
// - select fall starts timed word store
// - word write needs no prior erase
// - erase leaves location all ones
// - power-up disabled; enable needed before programming
// - enable holds until disable or power-off
// - disabled device ignores program and erase
// - reads work regardless of enable latch
// - clear-all sets every bit to one
// - fill-all writes word everywhere, no erase
`include "eeprom_params.svh"

module serial_eeprom #(
  parameter bit          LARGE_ADDR  = 1'b1,
  parameter int unsigned PROG_CYCLES = `EE_PROG_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  input  wire logic org_x16,
  output logic      serial_out,
  output logic      serial_out_en,
  output logic      busy
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    logic                    sk_prev;
    logic                    cs_prev;
    eeprom_pkg::rx_state_t   rx;
    eeprom_pkg::pg_state_t   pg;
    logic [4:0]              cnt;
    logic [15:0]             sr;
    logic [1:0]              opc;
    logic [1:0]              sub;
    logic [7:0]              addr;
    logic [15:0]             dout;
    logic [4:0]              rdcnt;
    logic                    oen;
    logic                    oval;
    logic                    we_en;
    logic                    pend;
    logic                    stat_arm;
    logic                    stat_on;
    logic                    stat_rel;
    logic [7:0]              idx;
    logic [7:0]              last;
    logic [15:0]             fdata;
    logic [`EE_TIMER_W-1:0]  timer;
  } state_t;

  state_t q;
  state_t d;

  logic [7:0] mem [0:`EE_BYTES-1];

  logic       cs_s;
  logic       sk_s;
  logic       di_s;
  logic       x16_s;
  logic       sk_rise;
  logic       sk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic [4:0] addr_bits;
  logic [4:0] data_bits;
  logic [4:0] cnt_next;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [15:0] rd_word;
  logic [7:0] in_addr;
  logic [7:0] base;
  logic [15:0] in_data;
  logic       mem_we;
  logic [7:0] mem_d;
  logic       ready;

  localparam logic [`EE_TIMER_W-1:0] PROG_LAST = `EE_TIMER_W'(PROG_CYCLES - 1);

  // ========================================================================
  // pin synchronisers
  // ========================================================================
  sync2 u_sync_cs (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (chip_select),
    .level   (cs_s)
  );

  sync2 u_sync_sk (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (serial_clock),
    .level   (sk_s)
  );

  sync2 u_sync_di (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (serial_in),
    .level   (di_s)
  );

  sync2 u_sync_org (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (org_x16),
    .level   (x16_s)
  );

  // ========================================================================
  // edges and instruction geometry
  // ========================================================================
  assign sk_rise   = sk_s & ~q.sk_prev;
  assign sk_fall   = ~sk_s & q.sk_prev;
  assign cs_rise   = cs_s & ~q.cs_prev;
  assign cs_fall   = ~cs_s & q.cs_prev;
  // address length: base, +1 large variant, +1 byte organisation
  assign addr_bits = `EE_ADDR_BASE + {4'h0, LARGE_ADDR} + {4'h0, ~x16_s};
  assign data_bits = x16_s ? `EE_DATA_X16 : `EE_DATA_X8;
  assign cnt_next  = q.cnt + 5'h01;
  assign in_addr   = {q.sr[6:0], di_s};
  assign in_data   = {q.sr[14:0], di_s};
  assign ready     = (q.pg == eeprom_pkg::PG_IDLE);

  // top address bit of the large variant falls off here
  assign base = x16_s ? {in_addr[6:0], 1'b0} : in_addr;

  // read fetch address: new address during command, next word while reading
  always_comb begin
    if (q.rx == eeprom_pkg::RX_READ) begin
      rd_a = q.addr + 8'h01;
    end else begin
      rd_a = in_addr;
    end
  end

  // word fetch, byte data left-aligned so the MSB leaves first
  always_comb begin
    rd_b = x16_s ? {rd_a[6:0], 1'b0} : rd_a;
    if (x16_s) begin
      rd_word = {mem[rd_b], mem[rd_b | 8'h01]};
    end else begin
      rd_word = {mem[rd_b], 8'h00};
    end
  end

  // ========================================================================
  // next-state logic
  // ========================================================================
  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    mem_d     = q.idx[0] ? q.fdata[7:0] : q.fdata[15:8];
    d.sk_prev = sk_s;
    d.cs_prev = cs_s;

    // self-timed program: store bytes, then hold busy for the pulse
    case (q.pg)
      eeprom_pkg::PG_IDLE: begin
      end
      eeprom_pkg::PG_FILL: begin
        mem_we = 1'b1;
        if (q.idx == q.last) begin
          d.pg    = eeprom_pkg::PG_TIME;
          d.timer = '0;
        end else begin
          d.idx = q.idx + 8'h01;
        end
      end
      eeprom_pkg::PG_TIME: begin
        if (q.timer == PROG_LAST) begin
          d.pg = eeprom_pkg::PG_IDLE;
        end else begin
          d.timer = q.timer + `EE_TIMER_W'(1);
        end
      end
      default: begin
        d.pg = eeprom_pkg::PG_IDLE;
      end
    endcase

    // instruction receiver
    case (q.rx)
      eeprom_pkg::RX_OFF: begin
      end
      eeprom_pkg::RX_HUNT: begin
        // leading zeros skipped; no new instruction while busy
        if (sk_rise && di_s && ready) begin
          d.rx  = eeprom_pkg::RX_CMD;
          d.cnt = '0;
        end
      end
      eeprom_pkg::RX_CMD: begin
        if (sk_rise) begin
          d.sr  = in_data;
          d.cnt = cnt_next;
          if (cnt_next == `EE_OPC_BITS) begin
            d.opc = {q.sr[0], di_s};
          end
          if (cnt_next == `EE_SUB_BITS) begin
            d.sub = {q.sr[0], di_s};
          end
          if (cnt_next == `EE_OPC_BITS + addr_bits) begin
            d.addr = in_addr;
            case (q.opc)
              `EE_OPC_READ: begin
                // leave high impedance with the dummy zero
                d.rx    = eeprom_pkg::RX_READ;
                d.oen   = 1'b1;
                d.oval  = 1'b0;
                d.dout  = rd_word;
                d.rdcnt = '0;
              end
              `EE_OPC_ERASE: begin
                d.rx    = eeprom_pkg::RX_DONE;
                d.pend  = 1'b1;
                d.idx   = base;
                d.last  = x16_s ? (base | 8'h01) : base;
                d.fdata = `EE_ERASED_WORD;
              end
              `EE_OPC_WRITE: begin
                d.idx  = base;
                d.last = x16_s ? (base | 8'h01) : base;
              end
              default: begin
                case (q.sub)
                  `EE_SUB_ENABLE: begin
                    d.we_en = 1'b1;
                    d.rx    = eeprom_pkg::RX_DONE;
                  end
                  `EE_SUB_DISABLE: begin
                    d.we_en = 1'b0;
                    d.rx    = eeprom_pkg::RX_DONE;
                  end
                  `EE_SUB_CLRALL: begin
                    d.rx    = eeprom_pkg::RX_DONE;
                    d.pend  = 1'b1;
                    d.idx   = 8'h00;
                    d.last  = `EE_LAST_BYTE;
                    d.fdata = `EE_ERASED_WORD;
                  end
                  default: begin
                    d.idx  = 8'h00;
                    d.last = `EE_LAST_BYTE;
                  end
                endcase
              end
            endcase
          end
          if (cnt_next == `EE_OPC_BITS + addr_bits + data_bits) begin
            // data word complete: write or fill-all waits for deselect
            d.rx    = eeprom_pkg::RX_DONE;
            d.pend  = 1'b1;
            d.fdata = x16_s ? in_data : {in_data[7:0], in_data[7:0]};
          end
        end
      end
      eeprom_pkg::RX_READ: begin
        if (sk_rise) begin
          d.oval = q.dout[15];
          d.dout = {q.dout[14:0], 1'b0};
          if (q.rdcnt == data_bits - 5'h01) begin
            // sequential read rolls on to the next word
            d.rdcnt = '0;
            d.addr  = rd_a;
            d.dout  = rd_word;
          end else begin
            d.rdcnt = q.rdcnt + 5'h01;
          end
        end
      end
      eeprom_pkg::RX_DONE: begin
      end
      default: begin
        d.rx = eeprom_pkg::RX_OFF;
      end
    endcase

    // status polling: ready level while selected
    if (q.stat_on) begin
      d.oval = ready;
      if (sk_rise && di_s) begin
        d.stat_rel = 1'b1;
      end
      if (q.stat_rel && sk_fall) begin
        d.oen      = 1'b0;
        d.stat_on  = 1'b0;
        d.stat_rel = 1'b0;
        d.stat_arm = 1'b0;
      end
    end

    // select rise clears the shifter and may show status
    if (cs_rise) begin
      d.rx  = eeprom_pkg::RX_HUNT;
      d.cnt = '0;
      d.sr  = '0;
      if (q.stat_arm) begin
        d.stat_on  = 1'b1;
        d.stat_rel = 1'b0;
        d.oen      = 1'b1;
        d.oval     = ready;
      end
    end

    // select fall ends output and launches pending program cycle
    if (cs_fall) begin
      d.rx       = eeprom_pkg::RX_OFF;
      d.oen      = 1'b0;
      d.stat_on  = 1'b0;
      d.stat_rel = 1'b0;
      d.pend     = 1'b0;
      if (q.pend && q.we_en && ready) begin
        d.pg       = eeprom_pkg::PG_FILL;
        d.stat_arm = 1'b1;
      end
    end
  end

  // ========================================================================
  // registers
  // ========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.rx       <= eeprom_pkg::RX_OFF;
      q.pg       <= eeprom_pkg::PG_IDLE;
      q.we_en    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // array store, one byte per cycle during fill
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[q.idx] <= mem_d;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign serial_out    = q.oval;
  assign serial_out_en = q.oen;
  assign busy          = ~ready;

endmodule

// File: serial_eeprom_sva.sv
// ==========================================================================
// link and program timing checks
// ==========================================================================
module serial_eeprom_sva #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic org_x16,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt_q;
  // length of the current busy period
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      cnt_q <= 0;
    else
      cnt_q <= busy ? cnt_q + 1 : 0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // deselected long enough for the synchroniser
  sequence s_desel;
    !chip_select [*5];
  endsequence
  // output bit moved while driving, not a status change
  sequence s_step;
    serial_out_en && $past(serial_out_en) && $changed(serial_out) && !$past(busy, 2);
  endsequence
  property p_desel; s_desel |-> !serial_out_en; endproperty
  property p_status; serial_out_en && $past(serial_out_en) && busy && $past(busy, 2)
    |-> !serial_out; endproperty
  property p_step; s_step |-> $past(serial_clock, 3); endproperty
  property p_release; $fell(serial_out_en) && chip_select && $past(chip_select, 5)
    |-> !$past(serial_clock, 2); endproperty
  property p_lead; $rose(serial_out_en) && $past(serial_clock, 3) |-> !serial_out; endproperty
  property p_launch; $rose(busy) |-> !$past(chip_select, 2) && !chip_select; endproperty
  property p_min; $fell(busy) |-> cnt_q >= PROG_CYCLES; endproperty
  property p_max; cnt_q <= PROG_CYCLES + 262; endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  a_status: assert property (p_status) else $error("status high while busy");
  a_step: assert property (p_step) else $error("read bit moved off clock rise");
  a_release: assert property (p_release) else $error("release off clock fall");
  a_lead: assert property (p_lead) else $error("read without leading zero");
  a_launch: assert property (p_launch) else $error("busy while selected");
  a_min: assert property (p_min) else $error("program period too short");
  a_max: assert property (p_max) else $error("program period too long");
endmodule

bind serial_eeprom serial_eeprom_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .chip_select(chip_select),
  .serial_clock(serial_clock), .serial_in(serial_in), .org_x16(org_x16),
  .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy));

// File: serial_eeprom_tb.sv
module serial_eeprom_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PC = 40;
  logic ref_clk, rst_b, org_x16, chip_select, serial_clock, serial_in;
  logic serial_out, serial_out_en, busy;
  logic [15:0] mem [128];
  logic [31:0] rng, r;
  logic [8:0] a;
  logic [15:0] d, e;
  int fail_count, check_count, cyc;

  serial_eeprom #(.LARGE_ADDR(1'b1), .PROG_CYCLES(PC)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .org_x16(org_x16),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy));
  host_model host (
    .chip_select(chip_select), .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));

  // ==========================================================================
  // clock, timeout and helpers
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  function automatic logic [31:0] nx();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic int aw();
    return org_x16 ? 8 : 9;
  endfunction
  function automatic int wd();
    return org_x16 ? 16 : 8;
  endfunction
  task chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one framed instruction, lz leading zeros, dw data bits
  task op(input logic [1:0] c, input logic [8:0] ad, input logic [15:0] dt, input int dw,
          input int lz);
    logic [31:0] v;
    v = {29'h0, 1'b1, c};
    v = (v << aw()) | 32'(ad);
    v = (v << dw) | 32'(dt);
    host.sel();
    host.shift(v, lz + 3 + aw() + dw, r);
    host.desel();
  endtask
  task spec(input logic [1:0] s, input logic [15:0] dt);
    op(2'h0, 9'(s) << (aw() - 2), dt, (s == 2'h1) ? wd() : 0, 0);
  endtask
  // read one unit and compare with dummy zero first
  task rd(input logic [8:0] ad, input logic [15:0] e, input int lz);
    host.sel();
    host.shift((32'h6 << aw() | 32'(ad)) << wd(), lz + 3 + aw() + wd(), r);
    host.desel();
    chk_bit("lead zero", 1'b0, r[wd()]);
    chk_word("read data", e, org_x16 ? r[15:0] : {8'h00, r[7:0]});
  endtask
  // poll status low then high, then release with a dummy one
  task wait_ready();
    host.sel();
    chk_bit("busy", 1'b1, busy);
    chk_bit("status busy", 1'b0, host.dline);
    for (int k = 0; k < 800 && host.dline !== 1'b1; k++)
      #40;
    chk_bit("status ready", 1'b1, host.dline);
    host.shift(32'h1, 1, r);
    #200;
    chk_bit("released", 1'b0, serial_out_en);
    host.desel();
  endtask
  // look while even the shortest word cycle would still be busy
  task no_launch();
    #400;
    chk_bit("no launch", 1'b0, busy);
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    rst_b = 1'b0;
    org_x16 = 1'b1;
    rng = 32'h0000D148;
    repeat (12) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    spec(2'h2, 16'h0000);
    no_launch();
    spec(2'h3, 16'h0000);
    spec(2'h2, 16'h0000);
    wait_ready();
    for (int i = 0; i < 128; i++)
      mem[i] = 16'hFFFF;
    for (int i = 0; i < 6; i++) begin
      a = {2'b00, 7'(nx())};
      d = 16'(nx());
      op(2'h1, a, d, 16, int'(nx() % 3));
      wait_ready();
      mem[a[6:0]] = d;
      rd(a, mem[a[6:0]], int'(nx() % 3));
    end
    op(2'h3, a, 16'h0000, 0, 0);
    wait_ready();
    rd(a, 16'hFFFF, 0);
    mem[a[6:0]] = 16'hFFFF;
    a = a ^ 9'h001;
    rd(a, mem[a[6:0]], 1);
    spec(2'h0, 16'h0000);
    op(2'h1, a, 16'h1234, 16, 0);
    no_launch();
    rd(a, mem[a[6:0]], 0);
    spec(2'h3, 16'h0000);
    host.sel();
    host.shift(32'h5A, 8, r);
    host.desel();
    no_launch();
    @(posedge ref_clk);
    #2 org_x16 = 1'b0;
    #400;
    d = {8'h00, 8'(nx())};
    spec(2'h1, d);
    wait_ready();
    rd(9'h0, d, 0);
    rd(9'h1FF, d, 2);
    // byte write on an odd address, neighbour keeps the fill byte
    e = {8'h00, 8'(nx())};
    op(2'h1, 9'h0A3, e, 8, 1);
    wait_ready();
    rd(9'h0A3, e, 0);
    rd(9'h0A2, d, 1);
    @(posedge ref_clk);
    #2 org_x16 = 1'b1;
    #400;
    rd(9'h055, {d[7:0], d[7:0]}, 0);
    test_done();
  end
endmodule

// File: sync2.sv
// ==========================================================================
// two-flop synchroniser for one pin
// ==========================================================================
module sync2 (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic meta;
    logic held;
  } sync_t;

  sync_t q;
  sync_t d;

  // first flop feeds only the second
  always_comb begin
    d      = q;
    d.meta = pin;
    d.held = q.meta;
  end

  // both stages cleared by reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // only the second stage leaves the module
  assign level = q.held;

endmodule
